// ### hdl/dac_pkg.sv
// Constants and types shared by the dual converter control block
package dac_pkg;
	// Register byte addresses (one aligned word each)
	localparam logic [7:0] ADDR_CONV1_CTRL_LOW  = 8'h00;
	localparam logic [7:0] ADDR_CONV1_CTRL_HIGH = 8'h04;
	localparam logic [7:0] ADDR_CONV2_CTRL      = 8'h08;
	localparam logic [7:0] ADDR_SHARED_LOW      = 8'h0c;
	localparam logic [7:0] ADDR_SHARED_HIGH     = 8'h10;
	localparam logic [7:0] ADDR_AUTO_TRIG       = 8'h14;
	localparam logic [7:0] ADDR_STATUS          = 8'h18;
	localparam logic [7:0] ADDR_RESULT1         = 8'h1c;
	localparam logic [7:0] ADDR_RESULT2         = 8'h20;

	// Converter control register fields
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_START_BIT  = 1;
	localparam int CTL_CHAN_LSB   = 2;
	localparam logic [7:0] CTL_WRITE_MASK = 8'h7d;

	// Shared register fields
	localparam int SH_PREF_LSB    = 0;
	localparam int SH_SYNC_BIT    = 2;
	localparam int SH_CLK_LSB     = 4;
	localparam int SH_JUSTIFY_BIT = 7;
	localparam logic [7:0] SH_WRITE_MASK = 8'hf3;

	// Auto trigger / double sample register fields
	localparam int AT_DSE1_BIT = 0;
	localparam int AT_DSE2_BIT = 1;
	localparam int AT_TRIG1_BIT = 2;
	localparam int AT_TRIG2_BIT = 3;

	// Status register fields
	localparam int ST_DONE1_BIT = 0;
	localparam int ST_DONE2_BIT = 1;

	localparam logic [7:0] RESET_VALUE = 8'h00;

	// Channel codes
	localparam logic [4:0] CH1_LOW_LAST   = 5'h02;
	localparam logic [4:0] CH1_HIGH_FIRST = 5'h0a;
	localparam logic [4:0] CH1_HIGH_LAST  = 5'h10;
	localparam logic [4:0] CH2_FIRST      = 5'h14;
	localparam logic [4:0] CH2_LAST       = 5'h1a;
	localparam logic [4:0] CH_POS_REF     = 5'h1b;
	localparam logic [4:0] CH_TEMP        = 5'h1d;
	localparam logic [4:0] CH_FIXED_REF   = 5'h1f;

	// Mux one-hot select index positions
	localparam int SEL_POS_REF   = 27;
	localparam int SEL_TEMP      = 28;
	localparam int SEL_FIXED_REF = 29;
	localparam int SEL_WIDTH     = 30;

	// Positive reference codes
	localparam logic [1:0] PREF_SUPPLY   = 2'h0;
	localparam logic [1:0] PREF_EXTERNAL = 2'h2;
	localparam logic [1:0] PREF_FIXED    = 2'h3;

	// Conversion clock: instruction cycle is four system clocks
	localparam int CLK_PER_INSTR = 4;
	// Result bits and conversion length in converter clocks
	localparam int RESULT_BITS = 10;
	localparam int CONV_TICKS  = 11;

	typedef enum logic [1:0] {
		DAC_IDLE,
		DAC_WAIT_RC,
		DAC_CONVERT
	} dac_state_t;

	typedef struct packed {
		dac_state_t  state;
		logic        enable;
		logic        start;
		logic [4:0]  channel;
		logic        dse;
		logic        second;
		logic [1:0]  rc_wait;
		logic [3:0]  ticks;
		logic        done_flag;
		logic        trig_last;
		logic [15:0] result;
	} dac_conv_t;
endpackage

// ### hdl/dac_ctrl.sv
// Control registers and conversion sequencing for two converters
`timescale 1ns/1ps
module dac_ctrl #(
	parameter int CONV_TICKS = dac_pkg::CONV_TICKS
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic [1:0]  i_rc_tick,
	input  wire logic [1:0]  i_trigger,
	input  wire logic [19:0] i_sample_bits,
	output logic      [1:0]  o_conv_power,
	output logic      [59:0] o_input_select,
	output logic      [1:0]  o_ref_supply,
	output logic      [1:0]  o_ref_external,
	output logic      [1:0]  o_ref_fixed,
	output logic      [1:0]  o_conv_done_flag
);
	// Tick counter is four bits wide
	if (CONV_TICKS < 2 || CONV_TICKS > 15) begin : g_bad_ticks
		$error("CONV_TICKS out of range");
	end

	typedef struct packed {
		dac_pkg::dac_conv_t [1:0] conv;
		logic                     justify;
		logic [2:0]               clk_sel;
		logic [1:0]               pref;
		logic                     sync;
		logic                     ack;
		logic [31:0]              rdata;
		logic [6:0]               div;
		logic [1:0]               trig_en;
	} dac_state_all_t;

	dac_state_all_t st_reg;
	dac_state_all_t st_next;

	logic       wr_en;
	logic       rd_en;
	logic       wr_byte;
	logic       hit;
	logic       is_rc;
	logic       conv_tick;
	logic [7:0] ctl_rd [2];
	logic [7:0] shared_rd;
	logic [7:0] div_max;
	logic [29:0] sel [2];

	assign wr_byte = wb_sel_i[0];
	assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && !st_reg.ack && wr_byte;
	assign rd_en   = wb_cyc_i && wb_stb_i && !st_reg.ack;
	assign is_rc   = (st_reg.clk_sel[1:0] == 2'h3);

	// Divider terminal count per clock select
	always_comb begin
		case (st_reg.clk_sel)
			3'h0:    div_max = 8'h01;
			3'h1:    div_max = 8'h07;
			3'h2:    div_max = 8'h1f;
			3'h4:    div_max = 8'h03;
			3'h5:    div_max = 8'h0f;
			3'h6:    div_max = 8'h3f;
			default: div_max = 8'h00;
		endcase
	end
	assign conv_tick = ({1'b0, st_reg.div} == div_max);

	// Register read images
	generate
		for (genvar c = 0; c < 2; c++) begin : g_rd
			always_comb begin
				ctl_rd[c] = 8'h00;
				ctl_rd[c][dac_pkg::CTL_ENABLE_BIT] = st_reg.conv[c].enable;
				ctl_rd[c][dac_pkg::CTL_START_BIT] = st_reg.conv[c].start;
				ctl_rd[c][dac_pkg::CTL_CHAN_LSB +: 5] = st_reg.conv[c].channel;
			end
		end
	endgenerate

	always_comb begin
		shared_rd = 8'h00;
		shared_rd[dac_pkg::SH_JUSTIFY_BIT] = st_reg.justify;
		shared_rd[dac_pkg::SH_CLK_LSB +: 3] = st_reg.clk_sel;
		shared_rd[dac_pkg::SH_SYNC_BIT] = st_reg.conv[0].start | st_reg.conv[1].start;
		shared_rd[dac_pkg::SH_PREF_LSB +: 2] = st_reg.pref;
	end

	always_comb begin
		logic [7:0] d;
		logic       sw_start [2];
		logic       sw_clear [2];
		logic       ctl_wr [2];
		logic       trig_rise;
		logic       tick;
		logic       last;
		logic [9:0] raw;
		d = wb_dat_i[7:0];
		sw_start = '{1'b0, 1'b0};
		sw_clear = '{1'b0, 1'b0};
		ctl_wr = '{1'b0, 1'b0};
		st_next = st_reg;
		trig_rise = 1'b0;
		tick = 1'b0;
		last = 1'b0;
		raw = 10'h000;
		hit = 1'b0;
		st_next.ack = 1'b0;
		st_next.rdata = 32'h0000_0000;
		ctl_wr[0] = wr_en && (wb_adr_i == dac_pkg::ADDR_CONV1_CTRL_LOW ||
			wb_adr_i == dac_pkg::ADDR_CONV1_CTRL_HIGH);
		ctl_wr[1] = wr_en && wb_adr_i == dac_pkg::ADDR_CONV2_CTRL;

		// Address decode and bus answer
		if (wb_adr_i == dac_pkg::ADDR_CONV1_CTRL_LOW ||
			wb_adr_i == dac_pkg::ADDR_CONV1_CTRL_HIGH) begin
			hit = 1'b1;
			st_next.rdata = {24'h000000, ctl_rd[0]};
		end else if (wb_adr_i == dac_pkg::ADDR_CONV2_CTRL) begin
			hit = 1'b1;
			st_next.rdata = {24'h000000, ctl_rd[1]};
		end else if (wb_adr_i == dac_pkg::ADDR_SHARED_LOW ||
			wb_adr_i == dac_pkg::ADDR_SHARED_HIGH) begin
			hit = 1'b1;
			st_next.rdata = {24'h000000, shared_rd};
		end else if (wb_adr_i == dac_pkg::ADDR_AUTO_TRIG) begin
			hit = 1'b1;
			st_next.rdata = {28'h0000000, st_reg.trig_en,
				st_reg.conv[1].dse, st_reg.conv[0].dse};
		end else if (wb_adr_i == dac_pkg::ADDR_STATUS) begin
			hit = 1'b1;
			st_next.rdata = {30'h00000000, st_reg.conv[1].done_flag,
				st_reg.conv[0].done_flag};
		end else if (wb_adr_i == dac_pkg::ADDR_RESULT1) begin
			hit = 1'b1;
			st_next.rdata = {16'h0000, st_reg.conv[0].result};
		end else if (wb_adr_i == dac_pkg::ADDR_RESULT2) begin
			hit = 1'b1;
			st_next.rdata = {16'h0000, st_reg.conv[1].result};
		end
		if (rd_en) begin
			st_next.ack = 1'b1;
		end
		if (!wb_we_i && !hit) begin
			st_next.rdata = 32'h0000_0000;
		end

		// Shared and option registers
		if (wr_en && (wb_adr_i == dac_pkg::ADDR_SHARED_LOW ||
			wb_adr_i == dac_pkg::ADDR_SHARED_HIGH)) begin
			st_next.justify = d[dac_pkg::SH_JUSTIFY_BIT];
			st_next.clk_sel = d[dac_pkg::SH_CLK_LSB +: 3];
			st_next.pref    = d[dac_pkg::SH_PREF_LSB +: 2];
		end
		if (wr_en && wb_adr_i == dac_pkg::ADDR_AUTO_TRIG) begin
			st_next.conv[0].dse = d[dac_pkg::AT_DSE1_BIT];
			st_next.conv[1].dse = d[dac_pkg::AT_DSE2_BIT];
			st_next.trig_en = d[dac_pkg::AT_TRIG2_BIT:dac_pkg::AT_TRIG1_BIT];
		end
		st_next.sync = wr_en && d[dac_pkg::SH_SYNC_BIT] &&
			(wb_adr_i == dac_pkg::ADDR_SHARED_LOW ||
			wb_adr_i == dac_pkg::ADDR_SHARED_HIGH);

		// Converter clock divider
		st_next.div = conv_tick ? 7'h00 : st_reg.div + 7'h01;

		for (int c = 0; c < 2; c++) begin
			sw_start[c] = ctl_wr[c] && d[dac_pkg::CTL_START_BIT];
			sw_clear[c] = ctl_wr[c] && !d[dac_pkg::CTL_START_BIT];
			trig_rise = st_reg.trig_en[c] && i_trigger[c] && !st_reg.conv[c].trig_last;
			st_next.conv[c].trig_last = i_trigger[c];
			tick = is_rc ? i_rc_tick[c] : conv_tick;
			if (ctl_wr[c]) begin
				st_next.conv[c].enable  = d[dac_pkg::CTL_ENABLE_BIT];
				st_next.conv[c].channel = d[dac_pkg::CTL_CHAN_LSB +: 5];
			end
			// Done flag cleared by writing zero to its status bit
			if (wr_en && wb_adr_i == dac_pkg::ADDR_STATUS && !d[c]) begin
				st_next.conv[c].done_flag = 1'b0;
			end
			if (!st_reg.conv[c].enable) begin
				st_next.conv[c].state = dac_pkg::DAC_IDLE;
				st_next.conv[c].start = 1'b0;
			end else begin
				case (st_reg.conv[c].state)
					dac_pkg::DAC_IDLE: begin
						if (sw_start[c] || st_reg.sync || trig_rise) begin
							st_next.conv[c].start = 1'b1;
							st_next.conv[c].second = 1'b0;
							st_next.conv[c].ticks = 4'h0;
							st_next.conv[c].rc_wait = 2'h0;
							st_next.conv[c].state = is_rc ?
								dac_pkg::DAC_WAIT_RC : dac_pkg::DAC_CONVERT;
						end
					end
					dac_pkg::DAC_WAIT_RC: begin
						// One instruction cycle before sampling
						st_next.conv[c].rc_wait = st_reg.conv[c].rc_wait + 2'h1;
						if (st_reg.conv[c].rc_wait == 2'(dac_pkg::CLK_PER_INSTR - 1)) begin
							st_next.conv[c].state = dac_pkg::DAC_CONVERT;
						end
						if (sw_clear[c]) begin
							st_next.conv[c].start = 1'b0;
							st_next.conv[c].state = dac_pkg::DAC_IDLE;
						end
					end
					dac_pkg::DAC_CONVERT: begin
						if (tick) begin
							st_next.conv[c].ticks = st_reg.conv[c].ticks + 4'h1;
						end
						last = tick && (st_reg.conv[c].ticks == 4'(CONV_TICKS - 1));
						// Result on abort or completion: all ten sampled bits, right-justified when justify is set, else left-justified
						raw = i_sample_bits[c*10 +: 10];
						if (sw_clear[c] || (last && (!st_reg.conv[c].dse ||
							st_reg.conv[c].second))) begin
							st_next.conv[c].result = st_reg.justify ?
								{6'h00, raw} : {raw, 6'h00};
							st_next.conv[c].start = 1'b0;
							st_next.conv[c].state = dac_pkg::DAC_IDLE;
							if (!sw_clear[c]) begin
								st_next.conv[c].done_flag = 1'b1;
							end
						end else if (last) begin
							st_next.conv[c].second = 1'b1;
							st_next.conv[c].ticks = 4'h0;
						end
					end
					default: begin
						st_next.conv[c].state = dac_pkg::DAC_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Input multiplexer select decode
	generate
		for (genvar c = 0; c < 2; c++) begin : g_mux
			always_comb begin
				logic [4:0] ch;
				ch = st_reg.conv[c].channel;
				sel[c] = 30'h00000000;
				if (ch == dac_pkg::CH_POS_REF) begin
					sel[c][dac_pkg::SEL_POS_REF] = 1'b1;
				end else if (ch == dac_pkg::CH_TEMP) begin
					sel[c][dac_pkg::SEL_TEMP] = 1'b1;
				end else if (ch == dac_pkg::CH_FIXED_REF) begin
					sel[c][dac_pkg::SEL_FIXED_REF] = 1'b1;
				end else if (c == 0 && (ch <= dac_pkg::CH1_LOW_LAST ||
					(ch >= dac_pkg::CH1_HIGH_FIRST && ch <= dac_pkg::CH1_HIGH_LAST))) begin
					sel[c][ch] = 1'b1;
				end else if (c == 1 && ch >= dac_pkg::CH2_FIRST &&
					ch <= dac_pkg::CH2_LAST) begin
					sel[c][ch] = 1'b1;
				end
				if (!st_reg.conv[c].enable) begin
					sel[c] = 30'h00000000;
				end
			end
		end
	endgenerate

	assign o_input_select = {sel[1], sel[0]};
	assign o_conv_power = {st_reg.conv[1].enable, st_reg.conv[0].enable};
	assign o_conv_done_flag = {st_reg.conv[1].done_flag, st_reg.conv[0].done_flag};
	generate
		for (genvar c = 0; c < 2; c++) begin : g_ref
			assign o_ref_supply[c]   = st_reg.conv[c].enable &&
				st_reg.pref == dac_pkg::PREF_SUPPLY;
			assign o_ref_external[c] = st_reg.conv[c].enable &&
				st_reg.pref == dac_pkg::PREF_EXTERNAL;
			assign o_ref_fixed[c]    = st_reg.conv[c].enable &&
				st_reg.pref == dac_pkg::PREF_FIXED;
		end
	endgenerate

	assign wb_dat_o = st_reg.rdata;
	assign wb_ack_o = st_reg.ack;
	assign wb_err_o = 1'b0;
endmodule

// ### bench/dac_monitor.sv
// Port checker for the dual converter control block
`timescale 1ns/1ps
module dac_monitor (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic [1:0]  o_conv_power,
	input wire logic [59:0] o_input_select,
	input wire logic [1:0]  o_ref_supply,
	input wire logic [1:0]  o_ref_external,
	input wire logic [1:0]  o_ref_fixed,
	input wire logic [1:0]  o_conv_done_flag
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	ack_on_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	no_error_a: assert property (!wb_err_o)
		else $error("error response seen");
	conv1_off_a: assert property (!o_conv_power[0] |-> o_input_select[29:0] == '0)
		else $error("disabled converter 1 still connected");
	conv2_off_a: assert property (!o_conv_power[1] |-> o_input_select[59:30] == '0)
		else $error("disabled converter 2 still connected");
	conv1_sel_a: assert property ($onehot0(o_input_select[29:0]) &&
		o_input_select[9:3] == '0 && o_input_select[26:17] == '0)
		else $error("converter 1 selects a reserved input");
	conv2_sel_a: assert property ($onehot0(o_input_select[59:30]) &&
		o_input_select[49:30] == '0)
		else $error("converter 2 selects a reserved input");
	ref_route_a: assert property ($onehot0({o_ref_supply[0], o_ref_external[0],
		o_ref_fixed[0]}) && $onehot0({o_ref_supply[1], o_ref_external[1], o_ref_fixed[1]}))
		else $error("two reference sources at once");
	flag_sticky_a: assert property (!(wb_cyc_i && wb_we_i) |=>
		(o_conv_done_flag & $past(o_conv_done_flag)) == $past(o_conv_done_flag))
		else $error("done flag cleared without software");
	reset_clear_a: assert property ($rose(i_rst_n) |->
		o_conv_power == 2'h0 && o_conv_done_flag == 2'h0)
		else $error("state not cleared by reset");
endmodule

bind dac_ctrl dac_monitor u_mon (.i_ref_clk, .i_rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_ack_o, .wb_err_o, .o_conv_power, .o_input_select, .o_ref_supply, .o_ref_external,
	.o_ref_fixed, .o_conv_done_flag);

// ### bench/dac_analog_model.sv
// Analog core model: sample bits and internal RC clock ticks
`timescale 1ns/1ps
module dac_analog_model (
	input  wire logic        i_ref_clk,
	input  wire logic [1:0]  i_power,
	input  wire logic [19:0] i_level,
	output logic      [19:0] o_sample_bits,
	output logic      [1:0]  o_rc_tick
);
	logic [1:0] div_reg = 2'h0;

	always @(posedge i_ref_clk) begin
		div_reg <= div_reg + 2'h1;
	end
	// RC clock slower than system clock, stopped when powered down
	assign o_rc_tick = i_power & {2{div_reg == 2'h3}};
	// Powered-down core gives a toggling pattern, not the level
	assign o_sample_bits[9:0] = i_power[0] ? i_level[9:0] : {10{div_reg[0]}};
	assign o_sample_bits[19:10] = i_power[1] ? i_level[19:10] : {10{div_reg[0]}};
endmodule

// ### bench/dac_ctrl_tb_top.sv
// Self-checking bench for the dual converter control block
`timescale 1ns/1ps
module dac_ctrl_tb_top;
	logic        i_ref_clk = 1'b0;
	logic        i_rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, chk;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [1:0]  i_rc_tick, i_trigger, o_conv_power, o_ref_supply, o_ref_external;
	logic [1:0]  o_ref_fixed, o_conv_done_flag;
	logic [19:0] i_sample_bits, lvl;
	logic [59:0] o_input_select;
	logic [31:0] rs = 32'h1f;
	logic [31:0] exp_q[$], msk_q[$];
	logic [7:0]  ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'hf0};
	int          num_errors = 0;
	int          total_checks = 0;

	always #5 i_ref_clk = ~i_ref_clk;

	dac_ctrl #(.CONV_TICKS(4)) dut (.i_ref_clk, .i_rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .i_rc_tick,
		.i_trigger, .i_sample_bits, .o_conv_power, .o_input_select, .o_ref_supply,
		.o_ref_external, .o_ref_fixed, .o_conv_done_flag);
	dac_analog_model u_ana (.i_ref_clk, .i_power(o_conv_power), .i_level(lvl),
		.o_sample_bits(i_sample_bits), .o_rc_tick(i_rc_tick));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	function automatic logic [29:0] sel(input logic [4:0] c, input logic two);
		logic [29:0] v;
		v = '0;
		if (!two && (c <= 5'h02 || (c >= 5'h0a && c <= 5'h10))) v[c] = 1'b1;
		if (two && c >= 5'h14 && c <= 5'h1a) v[c] = 1'b1;
		if (c == 5'h1b) v[27] = 1'b1;
		if (c == 5'h1d) v[28] = 1'b1;
		if (c == 5'h1f) v[29] = 1'b1;
		return v;
	endfunction

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [31:0] e, input logic [31:0] m);
		int n;
		n = 0;
		if (m != 0) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
		end
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, chk} <=
			{2'h3, w, a, 4'h1, 24'h0, d, m != 0};
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		if (wb_ack_o !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: no bus answer", $time);
		end
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, chk} <= 3'h0;
		@(posedge i_ref_clk);
	endtask

	// Poll a busy bit; the first read must still show it set
	task automatic poll(input logic [7:0] a, input int b);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 8'h00, 0, 0);
			n++;
			if (n == 1) check(32'(rd[b]), 32'h1);
		end while (rd[b] && n < 400);
		check(32'(rd[b]), 32'h0);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	always @(posedge i_ref_clk) begin
		if (wb_ack_o === 1'b1 && chk) begin
			check(wb_dat_o & msk_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end

	initial begin
		#500us;
		num_errors++;
		wrap_up();
	end

	initial begin
		{i_rst_n, wb_cyc_i, wb_stb_i, wb_we_i, chk, i_trigger} <= '0;
		{wb_adr_i, wb_sel_i, wb_dat_i, lvl} <= '0;
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		@(posedge i_ref_clk);
		foreach (ra[i]) bus(1'b0, ra[i], 8'h00, 32'h0, 32'hffffffff);
		bus(1'b1, 8'h00, 8'hfe, 0, 0);
		bus(1'b0, 8'h04, 8'h00, 32'h7c, 32'hff);
		bus(1'b1, 8'h10, 8'hff, 0, 0);
		bus(1'b0, 8'h0c, 8'h00, 32'hf3, 32'hff);
		$display("done: register access");
		for (int c = 0; c < 32; c++) begin
			bus(1'b1, 8'h00, {1'b1, 5'(c), 2'b01}, 0, 0);
			bus(1'b1, 8'h08, {1'b0, 5'(c), 2'b00}, 0, 0);
			check(32'(o_input_select[59:30]), 32'h0);
			bus(1'b1, 8'h08, {1'b1, 5'(c), 2'b01}, 0, 0);
			check(32'(o_input_select[29:0]), 32'(sel(5'(c), 1'b0)));
			check(32'(o_input_select[59:30]), 32'(sel(5'(c), 1'b1)));
		end
		$display("done: channel routing");
		for (int p = 0; p < 4; p++) begin
			bus(1'b1, 8'h0c, 8'(p), 0, 0);
			check(32'({o_ref_supply, o_ref_external, o_ref_fixed}),
				32'({{2{p == 0}}, {2{p == 2}}, {2{p == 3}}}));
		end
		$display("done: reference routing");
		for (int k = 0; k < 10; k++) begin
			bus(1'b1, 8'h14, {5'h0, k == 9, 1'b0, k == 8}, 0, 0);
			bus(1'b1, 8'h0c, {k[0], k[2:0], 4'h0}, 0, 0);
			bus(1'b1, 8'h00, 8'h01, 0, 0);
			rs = xs(rs);
			lvl <= rs[19:0];
			if (k == 9) begin
				i_trigger <= 2'h1;
				@(posedge i_ref_clk);
			end else begin
				bus(1'b1, 8'h00, 8'h03, 0, 0);
			end
			poll(8'h00, 1);
			bus(1'b0, 8'h18, 8'h00, 32'h1, 32'h1);
			bus(1'b0, 8'h1c, 8'h00, k[0] ? {22'h0, lvl[9:0]} :
				{16'h0, lvl[9:0], 6'h0}, 32'hffff);
			bus(1'b1, 8'h18, 8'h00, 0, 0);
			i_trigger <= 2'h0;
		end
		$display("done: single conversions");
		bus(1'b1, 8'h14, 8'h00, 0, 0);
		bus(1'b1, 8'h08, 8'h51, 0, 0);
		bus(1'b1, 8'h0c, 8'h64, 0, 0);
		bus(1'b0, 8'h08, 8'h00, 32'h2, 32'h2);
		poll(8'h10, 2);
		bus(1'b0, 8'h18, 8'h00, 32'h3, 32'h3);
		$display("done: synchronized start");
		bus(1'b1, 8'h18, 8'h00, 0, 0);
		rs = xs(rs);
		lvl <= rs[19:0];
		bus(1'b1, 8'h00, 8'h03, 0, 0);
		bus(1'b1, 8'h00, 8'h01, 0, 0);
		bus(1'b0, 8'h00, 8'h00, 32'h1, 32'hff);
		bus(1'b0, 8'h18, 8'h00, 32'h0, 32'h3);
		bus(1'b0, 8'h1c, 8'h00, {16'h0, lvl[9:0], 6'h0}, 32'hffff);
		$display("done: abort");
		wrap_up();
	end
endmodule
